// ### include/dsg_pkg.sv
// Package with constants and types of the debug security gate
package dsg_pkg;

	// ----------------------------------------------------------------
	// Bus answers and register map
	// ----------------------------------------------------------------
	localparam logic [1:0]  AXI_OKAY     = 2'h0;
	localparam logic [1:0]  AXI_SLVERR   = 2'h2;
	localparam logic [9:0]  OPT_IDX      = 10'h0C3;
	localparam logic [9:0]  ID_IDX_FIRST = 10'h0C4;
	localparam logic [9:0]  ID_IDX_LAST  = 10'h0CD;
	localparam logic [3:0]  ID_LEN       = 4'hA;
	localparam logic [3:0]  ID_LAST_POS  = 4'h9;
	localparam logic [11:0] A_CTRL       = 12'h000;
	localparam logic [11:0] A_STAT       = 12'h004;
	localparam logic [11:0] A_IRQ_ST     = 12'h008;
	localparam logic [11:0] A_IRQ_MK     = 12'h00C;
	localparam logic [11:0] A_USER_VEC   = 12'h010;
	localparam logic [11:0] A_USER_SP    = 12'h014;
	localparam logic [11:0] A_ROM_END    = 12'h018;
	localparam logic [11:0] A_RST_VEC    = 12'h01C;
	localparam logic [11:0] A_MON_BASE   = 12'h020;
	localparam logic [11:0] A_DBG_SP     = 12'h024;
	localparam logic [5:0]  A_SID_PAGE   = 6'h01;

	// ----------------------------------------------------------------
	// Field positions and values
	// ----------------------------------------------------------------
	localparam int          C_START      = 0;
	localparam int          C_ERASE      = 1;
	localparam int          C_TWO_WIRE   = 2;
	localparam int          C_RRM_USED   = 3;
	localparam int          C_RUN        = 4;
	localparam int          C_BREAK      = 5;
	localparam int          C_END        = 6;
	localparam logic [7:0]  CTRL_CFG     = 8'h0C;
	localparam int          E_GRANT      = 0;
	localparam int          E_FAIL       = 1;
	localparam int          E_ERASED     = 2;
	localparam int          OPT_EN_BIT   = 7;
	localparam logic [7:0]  OPT_NO_DEBUG = 8'h04;
	localparam logic [7:0]  OPT_KEEP     = 8'h85;
	localparam logic [7:0]  OPT_ERASE    = 8'h84;
	localparam logic [7:0]  OPT_VAR_MASK = 8'h0E;
	localparam logic [7:0]  OPT_VAR_INIT = 8'h04;
	localparam logic [1:0]  WHY_NONE     = 2'h0;
	localparam logic [1:0]  WHY_LOCK     = 2'h1;
	localparam logic [1:0]  WHY_BADID    = 2'h2;
	localparam logic [1:0]  WHY_NOEMU    = 2'h3;

	// ----------------------------------------------------------------
	// Reset values, sizes and timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  FLASH_ERASED = 8'hFF;
	localparam logic [19:0] ROM_END_RST  = 20'h3FFFF;
	localparam logic [19:0] USER_VEC_RST = 20'h00000;
	localparam logic [19:0] USER_SP_RST  = 20'hFFE00;
	localparam logic [19:0] MON_FULL     = 20'h00400;
	localparam logic [19:0] MON_SMALL    = 20'h00058;
	localparam logic [19:0] DBG_STACK    = 20'h00006;
	localparam int          CLK_MHZ      = 200;
	localparam int          ERASE_NS     = 1000;
	localparam int          ERASE_CYC    = (ERASE_NS * CLK_MHZ) / 1000;
	localparam logic [7:0]  ERASE_LAST   = 8'(ERASE_CYC - 1);

	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_CHECK = 5'h02,
		S_ERASE = 5'h04,
		S_GRANT = 5'h08,
		S_DENY  = 5'h10
	} dsg_state_t;

endpackage

// ### include/dsg_cmp_if.sv
// Interface between the gate and its security ID comparator
`timescale 1ns/1ps
interface dsg_cmp_if;
	logic       start;
	logic [3:0] idx;
	logic [7:0] exp_b;
	logic [7:0] got_b;
	logic       done;
	logic       match;

	modport ctl (output start, output exp_b, output got_b,
		input idx, input done, input match);
	modport cmp (input start, input exp_b, input got_b,
		output idx, output done, output match);
endinterface

// ### hdl/dsg_id_cmp.sv
// Byte serial comparator of supplied and stored security ID
`timescale 1ns/1ps
module dsg_id_cmp (
	input  wire logic sys_clk_in,
	input  wire logic reset_in,
	dsg_cmp_if.cmp    cmp_port
);
	import dsg_pkg::*;

	typedef struct packed {
		logic       busy;
		logic [3:0] idx;
		logic       ok;
		logic       done;
		logic       match;
	} dsg_cmp_regs_t;

	dsg_cmp_regs_t r;
	dsg_cmp_regs_t n;
	logic          eq;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		eq = (cmp_port.exp_b == cmp_port.got_b);
		n.done = 1'b0;
		if (cmp_port.start) begin
			n.busy = 1'b1;
			n.idx = 4'h0;
			n.ok = 1'b1;
			n.match = 1'b0;
		end else if (r.busy) begin
			if (r.idx == ID_LAST_POS) begin
				n.busy = 1'b0;
				n.done = 1'b1;
				n.match = r.ok && eq;
			end else begin
				n.idx = r.idx + 4'h1;
				n.ok = r.ok && eq;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign cmp_port.idx = r.idx;
	assign cmp_port.done = r.done;
	assign cmp_port.match = r.match;
endmodule

// ### hdl/dsg_gate.sv
// Debug security gate with option byte, security ID and register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps

module dsg_gate (
	input  wire logic                 sys_clk_in,
	input  wire logic                 reset_in,
	input  wire logic [11:0]          s_axi_awaddr_in,
	input  wire logic                 s_axi_awvalid_in,
	output logic                      s_axi_awready_out,
	input  wire logic [31:0]          s_axi_wdata_in,
	input  wire logic [3:0]           s_axi_wstrb_in,
	input  wire logic                 s_axi_wvalid_in,
	output logic                      s_axi_wready_out,
	output logic [1:0]                s_axi_bresp_out,
	output logic                      s_axi_bvalid_out,
	input  wire logic                 s_axi_bready_in,
	input  wire logic [11:0]          s_axi_araddr_in,
	input  wire logic                 s_axi_arvalid_in,
	output logic                      s_axi_arready_out,
	output logic [31:0]               s_axi_rdata_out,
	output logic [1:0]                s_axi_rresp_out,
	output logic                      s_axi_rvalid_out,
	input  wire logic                 s_axi_rready_in,
	input  wire logic                 emu_present_in,
	output logic                      irq_out,
	output logic                      session_out,
	output logic                      erase_out,
	output logic                      comm_init_out,
	output logic                      cpu_run_out,
	output logic [19:0]               reset_vector_out,
	output logic [19:0]               monitor_base_out,
	output logic [19:0]               debug_stack_out,
	output dsg_pkg::dsg_state_t       state_out
);
	import dsg_pkg::*;

	typedef struct packed {
		dsg_state_t  st;
		logic        aw_h;
		logic [11:0] aw_a;
		logic        w_h;
		logic [31:0] w_d;
		logic [3:0]  w_s;
		logic        b_v;
		logic [1:0]  b_r;
		logic        r_v;
		logic [31:0] r_d;
		logic [1:0]  r_r;
		logic [7:0]  opt;
		logic [79:0] id;
		logic [79:0] sid;
		logic [7:0]  ctrl;
		logic [2:0]  irq_st;
		logic [2:0]  irq_mk;
		logic [19:0] uvec;
		logic [19:0] usp;
		logic [19:0] rom_end;
		logic [19:0] rvec;
		logic [19:0] mbase;
		logic [19:0] dsp;
		logic [1:0]  why;
		logic [7:0]  ecnt;
		logic        run;
		logic        init;
		logic        emu;
		logic [2:0]  sync;
	} dsg_regs_t;

	dsg_regs_t   r;
	dsg_regs_t   n;
	dsg_cmp_if   cmp_bus ();
	logic        aw_rdy;
	logic        w_rdy;
	logic        ar_rdy;
	logic        wr_go;
	logic [9:0]  widx;
	logic [9:0]  ridx;
	logic [3:0]  wk;
	logic [3:0]  rk;
	logic [7:0]  opt_m;
	logic [7:0]  wbyte;
	logic [2:0]  ev;
	logic [2:0]  clr;
	logic        cmd_start;
	logic        cmd_erase;
	logic        cmd_run;
	logic        cmd_break;
	logic        cmd_end;
	logic        cmp_go;
	logic [19:0] msize;
	logic [31:0] mw;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[8*i +: 8] = d[8*i +: 8];
			end
		end
		return m;
	endfunction

	// ----------------------------------------------------------------
	// Comparator
	// ----------------------------------------------------------------
	dsg_id_cmp u_cmp (
		.sys_clk_in (sys_clk_in),
		.reset_in   (reset_in),
		.cmp_port   (cmp_bus.cmp)
	);

	assign cmp_bus.start = cmp_go;
	assign cmp_bus.exp_b = r.id[{cmp_bus.idx, 3'h0} +: 8];
	assign cmp_bus.got_b = r.sid[{cmp_bus.idx, 3'h0} +: 8];

	assign aw_rdy = !r.aw_h && !r.b_v;
	assign w_rdy = !r.w_h && !r.b_v;
	assign ar_rdy = !r.r_v;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		ev = 3'h0;
		clr = 3'h0;
		cmd_start = 1'b0;
		cmd_erase = 1'b0;
		cmd_run = 1'b0;
		cmd_break = 1'b0;
		cmd_end = 1'b0;
		cmp_go = 1'b0;
		mw = 32'h0000_0000;
		n.init = 1'b0;

		// Emulator pin, change taken once stages two and three agree
		n.sync = {r.sync[1:0], emu_present_in};
		if (r.sync[1] == r.sync[2]) begin
			n.emu = r.sync[2];
		end

		// Option byte with the device-owned bits at their initial values
		opt_m = (r.opt & ~OPT_VAR_MASK) | OPT_VAR_INIT;

		// Write channel
		if (s_axi_awvalid_in && aw_rdy) begin
			n.aw_h = 1'b1;
			n.aw_a = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && w_rdy) begin
			n.w_h = 1'b1;
			n.w_d = s_axi_wdata_in;
			n.w_s = s_axi_wstrb_in;
		end
		if (r.b_v && s_axi_bready_in) begin
			n.b_v = 1'b0;
		end
		wr_go = r.aw_h && r.w_h && !r.b_v;
		widx = r.aw_a[11:2];
		wk = 4'(widx - ID_IDX_FIRST);
		wbyte = r.w_s[0] ? r.w_d[7:0] : 8'h00;
		if (wr_go) begin
			n.aw_h = 1'b0;
			n.w_h = 1'b0;
			n.b_v = 1'b1;
			n.b_r = AXI_OKAY;
			if (widx == OPT_IDX) begin
				if (r.w_s[0] && r.st != S_ERASE) begin
					n.opt = r.w_d[7:0];
				end
			end else if (widx >= ID_IDX_FIRST && widx <= ID_IDX_LAST) begin
				if (r.w_s[0] && r.st != S_ERASE) begin
					n.id[{wk, 3'h0} +: 8] = r.w_d[7:0];
				end
			end else if (r.aw_a[11:6] == A_SID_PAGE && r.aw_a[5:2] < ID_LEN) begin
				if (r.w_s[0]) begin
					n.sid[{r.aw_a[5:2], 3'h0} +: 8] = r.w_d[7:0];
				end
			end else begin
				case ({r.aw_a[11:2], 2'h0})
					A_CTRL: begin
						if (r.w_s[0]) begin
							n.ctrl = wbyte & CTRL_CFG;
						end
						cmd_start = wbyte[C_START];
						cmd_erase = wbyte[C_ERASE];
						cmd_run = wbyte[C_RUN];
						cmd_break = wbyte[C_BREAK];
						cmd_end = wbyte[C_END];
					end
					A_IRQ_ST: begin
						clr = wbyte[2:0];
					end
					A_IRQ_MK: begin
						if (r.w_s[0]) begin
							n.irq_mk = r.w_d[2:0];
						end
					end
					A_USER_VEC: begin
						mw = merge({12'h000, r.uvec}, r.w_d, r.w_s);
						n.uvec = mw[19:0];
					end
					A_USER_SP: begin
						mw = merge({12'h000, r.usp}, r.w_d, r.w_s);
						n.usp = mw[19:0];
					end
					A_ROM_END: begin
						mw = merge({12'h000, r.rom_end}, r.w_d, r.w_s);
						n.rom_end = mw[19:0];
					end
					A_STAT, A_RST_VEC, A_MON_BASE, A_DBG_SP: begin
						n.b_r = AXI_OKAY;
					end
					default: begin
						n.b_r = AXI_SLVERR;
					end
				endcase
			end
		end

		// Read channel
		ridx = s_axi_araddr_in[11:2];
		rk = 4'(ridx - ID_IDX_FIRST);
		if (r.r_v && s_axi_rready_in) begin
			n.r_v = 1'b0;
		end
		if (s_axi_arvalid_in && ar_rdy) begin
			n.r_v = 1'b1;
			n.r_r = AXI_OKAY;
			n.r_d = 32'h0000_0000;
			if (ridx == OPT_IDX) begin
				n.r_d[7:0] = r.opt;
			end else if (ridx >= ID_IDX_FIRST && ridx <= ID_IDX_LAST) begin
				n.r_d[7:0] = r.id[{rk, 3'h0} +: 8];
			end else if (s_axi_araddr_in[11:6] == A_SID_PAGE
				&& s_axi_araddr_in[5:2] < ID_LEN) begin
				n.r_d[7:0] = r.sid[{s_axi_araddr_in[5:2], 3'h0} +: 8];
			end else begin
				case ({ridx, 2'h0})
					A_CTRL: n.r_d[7:0] = r.ctrl;
					A_STAT: n.r_d[8:0] = {r.run, r.emu, r.why, r.st};
					A_IRQ_ST: n.r_d[2:0] = r.irq_st;
					A_IRQ_MK: n.r_d[2:0] = r.irq_mk;
					A_USER_VEC: n.r_d[19:0] = r.uvec;
					A_USER_SP: n.r_d[19:0] = r.usp;
					A_ROM_END: n.r_d[19:0] = r.rom_end;
					A_RST_VEC: n.r_d[19:0] = r.rvec;
					A_MON_BASE: n.r_d[19:0] = r.mbase;
					A_DBG_SP: n.r_d[19:0] = r.dsp;
					default: n.r_r = AXI_SLVERR;
				endcase
			end
		end

		// ----------------------------------------------------------------
		// Gate sequence
		// ----------------------------------------------------------------
		case (r.st)
			S_IDLE, S_DENY: begin
				if (cmd_erase) begin
					n.st = S_ERASE;
					n.ecnt = 8'h00;
					n.why = WHY_NONE;
				end else if (cmd_start) begin
					if (!r.emu) begin
						n.st = S_DENY;
						n.why = WHY_NOEMU;
					end else if (!r.opt[OPT_EN_BIT]) begin
						n.st = S_DENY;
						n.why = WHY_LOCK;
					end else if (opt_m == OPT_NO_DEBUG) begin
						n.st = S_DENY;
						n.why = WHY_LOCK;
					end else if (opt_m != OPT_KEEP && opt_m != OPT_ERASE) begin
						n.st = S_DENY;
						n.why = WHY_LOCK;
					end else begin
						n.st = S_CHECK;
						n.why = WHY_NONE;
						cmp_go = 1'b1;
					end
				end
			end
			S_CHECK: begin
				if (cmp_bus.done) begin
					if (cmp_bus.match) begin
						n.st = S_GRANT;
						n.init = 1'b1;
						ev[E_GRANT] = 1'b1;
					end else begin
						ev[E_FAIL] = 1'b1;
						n.why = WHY_BADID;
						if (opt_m == OPT_ERASE) begin
							n.st = S_ERASE;
							n.ecnt = 8'h00;
						end else begin
							n.st = S_DENY;
						end
					end
				end
			end
			S_ERASE: begin
				if (r.ecnt == ERASE_LAST) begin
					n.opt = FLASH_ERASED;
					n.id = {10{FLASH_ERASED}};
					ev[E_ERASED] = 1'b1;
					n.st = (r.why == WHY_BADID) ? S_DENY : S_IDLE;
				end else begin
					n.ecnt = r.ecnt + 8'h01;
				end
			end
			S_GRANT: begin
				if (cmd_end || !r.emu) begin
					n.st = S_IDLE;
					n.run = 1'b0;
				end else begin
					if (cmd_run) begin
						n.run = 1'b1;
					end
					if (cmd_break) begin
						n.run = 1'b0;
					end
					n.opt[3:1] = {2'h1, r.run};
				end
			end
			default: begin
				n.st = S_IDLE;
			end
		endcase

		// ----------------------------------------------------------------
		// Sticky events and derived addresses
		// ----------------------------------------------------------------
		n.irq_st = (r.irq_st & ~clr) | ev;
		msize = (r.ctrl[C_TWO_WIRE] && !r.ctrl[C_RRM_USED]) ? MON_SMALL : MON_FULL;
		n.mbase = r.rom_end - msize + 20'h00001;
		n.rvec = (r.st == S_GRANT) ? r.mbase : r.uvec;
		n.dsp = r.usp - DBG_STACK;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			r <= '0;
			r.st <= S_IDLE;
			r.opt <= FLASH_ERASED;
			r.id <= {10{FLASH_ERASED}};
			r.sid <= '0;
			r.uvec <= USER_VEC_RST;
			r.usp <= USER_SP_RST;
			r.rom_end <= ROM_END_RST;
			r.rvec <= USER_VEC_RST;
			r.mbase <= ROM_END_RST - MON_FULL + 20'h00001;
			r.dsp <= USER_SP_RST - DBG_STACK;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_out = aw_rdy;
	assign s_axi_wready_out = w_rdy;
	assign s_axi_bresp_out = r.b_r;
	assign s_axi_bvalid_out = r.b_v;
	assign s_axi_arready_out = ar_rdy;
	assign s_axi_rdata_out = r.r_d;
	assign s_axi_rresp_out = r.r_r;
	assign s_axi_rvalid_out = r.r_v;
	assign irq_out = |(r.irq_st & r.irq_mk);
	assign session_out = (r.st == S_GRANT);
	assign erase_out = (r.st == S_ERASE);
	assign comm_init_out = r.init;
	assign cpu_run_out = r.run;
	assign reset_vector_out = r.rvec;
	assign monitor_base_out = r.mbase;
	assign debug_stack_out = r.dsp;
	assign state_out = r.st;
endmodule

// ### verif/dsg_emu_model.sv
// Emulator presence model for the debug security gate bench
`timescale 1ns/1ps
module dsg_emu_model (
	input  wire logic attach_in,
	output logic      emu_present_out
);
	initial emu_present_out = 1'h0;
	// Cable pin moves off the clock grid, like a real plug
	always @(attach_in) emu_present_out <= #1.3 attach_in;
endmodule

// ### verif/dsg_gate_properties.sv
// Property checker of the debug security gate
`timescale 1ns/1ps
module dsg_gate_chk (
	input wire logic               sys_clk_in,
	input wire logic               reset_in,
	input wire logic               emu_present_in,
	input wire logic               session_out,
	input wire logic               erase_out,
	input wire logic               comm_init_out,
	input wire logic               cpu_run_out,
	input wire logic [19:0]        reset_vector_out,
	input wire logic [19:0]        monitor_base_out,
	input wire dsg_pkg::dsg_state_t state_out
);
	import dsg_pkg::*;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	chk_erase_flag: assert property (erase_out == (state_out == S_ERASE))
		else $error("erase flag differs from state");
	chk_session_lvl: assert property (session_out == (state_out == S_GRANT))
		else $error("session flag differs from state");
	chk_grant_source: assert property ((state_out == S_GRANT && $past(state_out) != S_GRANT)
		|-> $past(state_out) == S_CHECK)
		else $error("grant without id check");
	chk_check_len: assert property ((state_out == S_CHECK && $past(state_out) != S_CHECK)
		|-> ##10 state_out == S_CHECK ##1 state_out != S_CHECK)
		else $error("id check length wrong");
	chk_erase_len: assert property ((erase_out && !$past(erase_out))
		|-> ##199 erase_out ##1 !erase_out)
		else $error("erase length wrong");
	chk_link_pulse: assert property (comm_init_out |-> session_out ##1 !comm_init_out)
		else $error("link init pulse wrong");
	chk_run_session: assert property (cpu_run_out |-> session_out)
		else $error("cpu run outside session");
	chk_vector_mon: assert property (session_out && $past(session_out)
		|-> reset_vector_out == monitor_base_out)
		else $error("reset vector not at monitor");
	chk_emu_gone: assert property (!emu_present_in [*6] |-> !session_out)
		else $error("session without emulator");

	cov_grant: cover property (comm_init_out);
	cov_erase: cover property (erase_out && !$past(erase_out));
	cov_run: cover property (cpu_run_out);
endmodule

bind dsg_gate dsg_gate_chk u_chk (.sys_clk_in, .reset_in, .emu_present_in, .session_out,
	.erase_out, .comm_init_out, .cpu_run_out, .reset_vector_out, .monitor_base_out,
	.state_out);

// ### verif/tb_dsg_gate.sv
// Self-checking bench of the debug security gate
`timescale 1ns/1ps
module tb_dsg_gate;
	import dsg_pkg::*;
	logic        sys_clk_in = 1'h0;
	logic        reset_in = 1'h1;
	logic [11:0] s_axi_awaddr_in = 12'h0;
	logic [11:0] s_axi_araddr_in = 12'h0;
	logic        s_axi_awvalid_in = 1'h0;
	logic        s_axi_wvalid_in = 1'h0;
	logic        s_axi_bready_in = 1'h0;
	logic        s_axi_arvalid_in = 1'h0;
	logic        s_axi_rready_in = 1'h0;
	logic [31:0] s_axi_wdata_in = 32'h0;
	logic [3:0]  s_axi_wstrb_in = 4'h0;
	logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic        s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rr;
	logic [31:0] s_axi_rdata_out, rv;
	logic        emu_present_in, irq_out, session_out, erase_out, comm_init_out, cpu_run_out;
	logic        attach = 1'h0;
	logic [19:0] reset_vector_out, monitor_base_out, debug_stack_out, uvec, val;
	dsg_state_t  state_out;
	int          bad_count = 0;
	int          compares = 0;
	integer      seed = 32'hB7F04E9F;
	logic [7:0]  cfg = 8'h0;
	logic [7:0]  id [10];
	logic [7:0]  opts [3] = '{OPT_KEEP, OPT_ERASE, OPT_NO_DEBUG};

	always #2.5 sys_clk_in = ~sys_clk_in;
	dsg_gate dut (.*);
	dsg_emu_model emu (.attach_in(attach), .emu_present_out(emu_present_in));

	// ----
	// Bus tasks and expectations
	// ----
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task stop_test;
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic av, wv, bv;
		logic [1:0] br;
		@(posedge sys_clk_in);
		s_axi_awaddr_in <= a;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= 4'hF;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		for (int n = 0; n < 40; n++) begin
			@(negedge sys_clk_in);
			av = s_axi_awready_out;
			wv = s_axi_wready_out;
			bv = s_axi_bvalid_out;
			br = s_axi_bresp_out;
			@(posedge sys_clk_in);
			if (av) s_axi_awvalid_in <= 1'h0;
			if (wv) s_axi_wvalid_in <= 1'h0;
			if (bv) break;
		end
		s_axi_bready_in <= 1'h0;
		@(negedge sys_clk_in);
		chk("bresp", br, er);
	endtask
	task rd(input logic [11:0] a);
		logic ar, v;
		@(posedge sys_clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		for (int n = 0; n < 40; n++) begin
			@(negedge sys_clk_in);
			ar = s_axi_arready_out;
			v = s_axi_rvalid_out;
			rv = s_axi_rdata_out;
			rr = s_axi_rresp_out;
			@(posedge sys_clk_in);
			if (ar) s_axi_arvalid_in <= 1'h0;
			if (v) break;
		end
		s_axi_rready_in <= 1'h0;
		@(negedge sys_clk_in);
	endtask
	task rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		rd(a);
		chk("rresp", rr, AXI_OKAY);
		chk(n, rv, e);
	endtask
	task cmd(input int b);
		wr(A_CTRL, 32'(cfg | (8'h01 << b)), AXI_OKAY);
	endtask
	task wait_st(input dsg_state_t s);
		for (int n = 0; n < 400; n++) begin
			@(negedge sys_clk_in);
			if (state_out === s) break;
		end
	endtask
	function automatic logic [19:0] mon_exp(logic [19:0] rom, logic [7:0] c);
		return rom - ((c[C_TWO_WIRE] && !c[C_RRM_USED]) ? MON_SMALL : MON_FULL) + 20'h1;
	endfunction
	function automatic logic [7:0] exp_res(logic [7:0] o, logic m, logic e);
		if (!e) return {1'h0, WHY_NOEMU, S_DENY};
		if (!o[OPT_EN_BIT] || (o != OPT_KEEP && o != OPT_ERASE)) return {1'h0, WHY_LOCK, S_DENY};
		if (m) return {1'h0, WHY_NONE, S_GRANT};
		return {o == OPT_ERASE, WHY_BADID, S_DENY};
	endfunction

	// ----
	// One debugger start attempt
	// ----
	task run_case(input logic [7:0] o, input logic m, input logic e);
		logic [7:0] x, s;
		x = exp_res(o, m, e);
		wr(12'h30C, o, AXI_OKAY);
		for (int k = 0; k < 10; k++) begin
			id[k] = 8'($random(seed));
			wr(12'(12'h310 + 4 * k), id[k], AXI_OKAY);
			wr(12'(12'h040 + 4 * k), (m || k != 9) ? id[k] : ~id[k], AXI_OKAY);
		end
		wr(A_IRQ_ST, 32'h7, AXI_OKAY);
		attach <= e;
		repeat (6) @(posedge sys_clk_in);
		cmd(C_START);
		if (x[7]) begin
			wait_st(S_ERASE);
			chk("erase", erase_out, 1'h1);
		end
		wait_st(dsg_state_t'(x[4:0]));
		chk("state", state_out, x[4:0]);
		chk("session", session_out, x[4:0] == S_GRANT);
		rd(12'h30C);
		chk("option", rv & ~OPT_VAR_MASK, (x[7] ? FLASH_ERASED : o) & ~OPT_VAR_MASK);
		if (x[7]) rchk("id", 12'h310, FLASH_ERASED);
		s = (x[4:0] == S_GRANT) ? 8'h01 : (x[6:5] == WHY_BADID) ? {5'h0, x[7], 2'h2} : 8'h00;
		rchk("irq status", A_IRQ_ST, s);
		chk("irq pin", irq_out, s != 8'h0);
		wr(A_IRQ_MK, 32'h0, AXI_OKAY);
		chk("irq masked", irq_out, 1'h0);
		wr(A_IRQ_MK, 32'h7, AXI_OKAY);
		if (x[4:0] != S_GRANT) begin
			rd(A_STAT);
			chk("reason", rv[6:5], x[6:5]);
		end else begin
			chk("vector", reset_vector_out, monitor_base_out);
			cmd(C_RUN);
			chk("run", cpu_run_out, 1'h1);
			rd(A_STAT);
			chk("run status", rv[8], 1'h1);
			cmd(C_BREAK);
			chk("break", cpu_run_out, 1'h0);
			cmd(C_END);
			chk("end", state_out, S_IDLE);
			chk("user vector", reset_vector_out, uvec);
		end
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (20) @(posedge sys_clk_in);
		reset_in <= 1'h0;
		rchk("user sp", A_USER_SP, 20'hFFE00);
		rchk("rom end", A_ROM_END, 20'h3FFFF);
		rchk("mon base", A_MON_BASE, 20'h3FC00);
		rchk("dbg sp", A_DBG_SP, 20'hFFDFA);
		rchk("option", 12'h30C, FLASH_ERASED);
		rchk("id last", 12'h334, FLASH_ERASED);
		wr(12'hFFC, 32'h1, AXI_SLVERR);
		rd(12'hFFC);
		chk("unmapped", {rr, rv}, {AXI_SLVERR, 32'h0});
		wr(A_MON_BASE, 32'h0, AXI_OKAY);
		rchk("ro base", A_MON_BASE, 20'h3FC00);
		wr(A_IRQ_MK, 32'h7, AXI_OKAY);
		uvec = 20'($random(seed));
		wr(A_USER_VEC, uvec, AXI_OKAY);
		chk("user vector", reset_vector_out, uvec);
		val = 20'($random(seed));
		wr(A_USER_SP, val, AXI_OKAY);
		rchk("dbg sp", A_DBG_SP, 20'(val - DBG_STACK));
		chk("stack pin", debug_stack_out, 20'(val - DBG_STACK));
		for (int i = 0; i < 4; i++) begin
			cfg = 8'(i << 2);
			val = 20'($random(seed)) | 20'h003FF;
			wr(A_ROM_END, val, AXI_OKAY);
			wr(A_CTRL, cfg, AXI_OKAY);
			rchk("mon base", A_MON_BASE, mon_exp(val, cfg));
			chk("mon pin", monitor_base_out, mon_exp(val, cfg));
			rchk("ctrl", A_CTRL, cfg);
		end
		run_case(OPT_KEEP, 1'h1, 1'h1);
		run_case(OPT_KEEP, 1'h0, 1'h1);
		run_case(OPT_ERASE, 1'h1, 1'h1);
		run_case(OPT_ERASE, 1'h0, 1'h1);
		run_case(OPT_NO_DEBUG, 1'h1, 1'h1);
		run_case(OPT_KEEP, 1'h1, 1'h0);
		run_case(8'h05, 1'h1, 1'h1);
		cmd(C_ERASE);
		wait_st(S_IDLE);
		rchk("restored", 12'h30C, FLASH_ERASED);
		for (int i = 0; i < 4; i++) begin
			run_case(opts[$unsigned($random(seed)) % 3], 1'($random(seed)), 1'h1);
		end
		stop_test;
	end

	initial begin
		#300000;
		bad_count++;
		stop_test;
	end
endmodule
